// ==== common/mdma_pkg.sv ====
// Constants, register map and types of the multichannel micro DMA controller
package mdma_pkg;
	// Channel count and table geometry
	localparam int NCH = 32;
	localparam logic [4:0] CH_MAX = 5'h1F;
	localparam int TBL_BYTES = 1024;
	localparam int TBL_ALIGN = 10;
	// APB register byte offsets
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_CFG = 12'h004;
	localparam logic [11:0] OFS_CTLBASE = 12'h008;
	localparam logic [11:0] OFS_ALTBASE = 12'h00C;
	localparam logic [11:0] OFS_SWREQ = 12'h010;
	localparam logic [11:0] OFS_ENASET = 12'h014;
	localparam logic [11:0] OFS_ENACLR = 12'h018;
	localparam logic [11:0] OFS_MASKSET = 12'h01C;
	localparam logic [11:0] OFS_MASKCLR = 12'h020;
	localparam logic [11:0] OFS_PRIOSET = 12'h024;
	localparam logic [11:0] OFS_PRIOCLR = 12'h028;
	localparam logic [11:0] OFS_ALTSET = 12'h02C;
	localparam logic [11:0] OFS_ALTCLR = 12'h030;
	localparam logic [11:0] OFS_ERRCLR = 12'h034;
	localparam logic [11:0] OFS_SECSET = 12'h038;
	localparam logic [11:0] OFS_SECCLR = 12'h03C;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [21:0] RST_BASE = 22'h000000;
	// Control word fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_CNT_LSB = 4;
	localparam int CTL_CNT_W = 10;
	localparam int CTL_SIZE_LSB = 24;
	localparam int CTL_SINC_LSB = 26;
	localparam int CTL_DINC_LSB = 30;
	// Structure word indices
	localparam logic [1:0] W_SRC = 2'h0;
	localparam logic [1:0] W_DST = 2'h1;
	localparam logic [1:0] W_CTL = 2'h2;
	// Item size and increment codes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] INC_NONE = 2'h3;
	// Transfer modes held in a structure
	typedef enum logic [2:0] {
		MD_STOP = 3'h0,
		MD_BASIC = 3'h1,
		MD_AUTO = 3'h2,
		MD_PINGPONG = 3'h3,
		MD_MSG = 3'h4,
		MD_MSG_ALT = 3'h5,
		MD_PSG = 3'h6,
		MD_PSG_ALT = 3'h7
	} mdma_mode_t;
	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FETCH = 3'h1,
		ST_CHECK = 3'h2,
		ST_READ = 3'h3,
		ST_WRITE = 3'h4,
		ST_WBACK = 3'h5
	} mdma_state_t;
endpackage

// ==== src/mdma_ctrl.sv ====
// Multichannel micro DMA controller: APB registers, arbiter and bus master engine
//
// Functional notes
// - Per-channel item width 8, 16 or 32
// - Addresses step byte, half, word or none
// - Two priority levels, set per channel
// - Yield system bus while processor uses it
// - One channel per peripheral direction, one software
// - Maskable peripheral requests, software request any channel
// - Basic mode moves only while request held
// - Auto mode finishes count after one request
// - Ping-pong alternates primary and alternate structures
// - Memory scatter-gather runs task list
// - Peripheral scatter-gather paced by request
// - Full table spans 1024 bytes
// - Alternate structure only for ping-pong, scatter-gather
// - Channel enable clears on completion; software disable
// - Remaining count readable, zero when done
// - Stopped code written into finished structure
// - Own interrupt: software channel and errors only
// - Completion sources clear themselves
// - Bus error flag held until software clears
// - Thirty-two channels numbered 0 to 31
// - Alternate structures at indices 32 to 63
// - Per-channel secondary request source select
//
// The APB slave port and the register offsets were chosen for this implementation.
module mdma_ctrl import mdma_pkg::*; #(
	parameter int SW_CH = 30
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [NCH-1:0] PERIPH_REQ,
	input wire logic [NCH-1:0] PERIPH_REQ_SEC,
	output logic [NCH-1:0] PERIPH_DONE,
	output logic IRQ,
	input wire logic CPU_BUSY,
	output logic M_REQ,
	output logic M_WRITE,
	output logic [31:0] M_ADDR,
	output logic [1:0] M_SIZE,
	output logic [31:0] M_WDATA,
	input wire logic M_ACK,
	input wire logic M_ERR,
	input wire logic [31:0] M_RDATA
);
	// Elaboration-time parameter check
	if (SW_CH < 0 || SW_CH >= NCH) begin : g_bad_sw_ch
		$error("SW_CH out of channel range");
	end

	// Lowest set bit of a channel vector
	function automatic logic [4:0] first_set(input logic [NCH-1:0] v);
		logic [4:0] idx;
		idx = 5'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction

	// Byte address of one structure word in the table
	function automatic logic [31:0] struct_addr(input logic [21:0] base, input logic alt,
		input logic [4:0] ch, input logic [1:0] w);
		return {base, alt, ch, w, 2'b00};
	endfunction

	// Address step for an increment code
	function automatic logic [31:0] step(input logic [1:0] inc);
		case (inc)
			SZ_BYTE: return 32'h00000001;
			SZ_HALF: return 32'h00000002;
			SZ_WORD: return 32'h00000004;
			default: return 32'h00000000;
		endcase
	endfunction

	// Extract an item from read lanes and replicate it over all lanes
	function automatic logic [31:0] lane_item(input logic [31:0] d, input logic [1:0] a,
		input logic [1:0] sz);
		logic [31:0] sh;
		sh = d >> {a, 3'b000};
		case (sz)
			SZ_BYTE: return {4{sh[7:0]}};
			SZ_HALF: return {2{sh[15:0]}};
			default: return d;
		endcase
	endfunction

	// Register state
	logic cfg_en_r;
	logic [21:0] base_r;
	logic [NCH-1:0] en_r, mask_r, prio_r, alt_r, sec_r, swreq_r, auto_r;
	logic err_r;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	// Request synchronisers
	logic [NCH-1:0] preq1_r, preq2_r, preqs1_r, preqs2_r;
	// Engine state
	mdma_state_t st_r;
	logic [4:0] ch_r;
	logic sel_r, sw_hit_r, last_r;
	logic [1:0] wi_r;
	logic [31:0] src_r, dst_r, ctl_r, data_r;
	mdma_mode_t mode_r;
	logic mreq_r, mwr_r;
	logic [31:0] maddr_r, mwdata_r;
	logic [1:0] msize_r;
	logic [NCH-1:0] done_r;
	logic irq_r;

	// Decoded bus writes and engine events
	logic apb_wr, bus_done, bus_err;
	logic [NCH-1:0] live_req, pend, hi_pend, hw_dis, hw_auto, ch_bit;
	logic [NCH-1:0] alt_tog, alt_set1, alt_clr1, done_nxt;
	logic [4:0] pick;
	logic [CTL_CNT_W-1:0] cnt_cur;
	mdma_mode_t mode_cur;
	logic paced;

	assign apb_wr = PSEL & PENABLE & PWRITE & pready_r;
	assign bus_done = mreq_r & M_ACK;
	assign bus_err = bus_done & M_ERR;
	assign ch_bit = NCH'(1) << ch_r;
	assign cnt_cur = ctl_r[CTL_CNT_LSB +: CTL_CNT_W];
	assign mode_cur = mdma_mode_t'(ctl_r[CTL_MODE_LSB +: 3]);

	// Request pins pass two flops before use
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			preq1_r <= RST_WORD;
			preq2_r <= RST_WORD;
			preqs1_r <= RST_WORD;
			preqs2_r <= RST_WORD;
		end else begin
			preq1_r <= PERIPH_REQ;
			preq2_r <= preq1_r;
			preqs1_r <= PERIPH_REQ_SEC;
			preqs2_r <= preqs1_r;
		end
	end

	// Request source select, masking and pending vector
	assign live_req = ((sec_r & preqs2_r) | (~sec_r & preq2_r)) & ~mask_r;
	assign pend = {NCH{cfg_en_r}} & en_r & (swreq_r | auto_r | live_req);
	assign hi_pend = pend & prio_r;
	assign pick = (|hi_pend) ? first_set(hi_pend) : first_set(pend);

	// Paced modes need a live request or a software kick per item
	assign paced = (mode_cur == MD_BASIC) || (mode_cur == MD_PSG) ||
		(mode_cur == MD_PSG_ALT);

	// Engine side effects on per-channel state
	always_comb begin
		hw_dis = '0;
		hw_auto = '0;
		alt_tog = '0;
		alt_set1 = '0;
		alt_clr1 = '0;
		done_nxt = '0;
		if (bus_err) begin
			hw_dis = ch_bit;
		end else if (st_r == ST_CHECK) begin
			if (mode_cur == MD_STOP) begin
				hw_dis = ch_bit;
			end else if (mode_cur == MD_AUTO || mode_cur == MD_MSG ||
				mode_cur == MD_MSG_ALT) begin
				hw_auto = ch_bit;
			end
		end else if (st_r == ST_WBACK && bus_done && wi_r == W_CTL) begin
			if (last_r) begin
				case (mode_r)
					MD_BASIC, MD_AUTO: begin
						hw_dis = ch_bit;
						alt_clr1 = ch_bit;
						done_nxt = ch_bit;
					end
					MD_PINGPONG: begin
						alt_tog = ch_bit;
						done_nxt = ch_bit;
					end
					MD_MSG, MD_PSG: alt_set1 = ch_bit;
					MD_MSG_ALT, MD_PSG_ALT: alt_clr1 = ch_bit;
					default: hw_dis = ch_bit;
				endcase
			end else if ((mode_r == MD_MSG || mode_r == MD_PSG) &&
				cnt_cur[1:0] == 2'h3) begin
				alt_set1 = ch_bit; // four-word task copied
			end
		end
	end

	// Global enable, table base, priority, mask and secondary select
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cfg_en_r <= 1'b0;
			base_r <= RST_BASE;
			prio_r <= RST_WORD;
			mask_r <= RST_WORD;
			sec_r <= RST_WORD;
		end else if (apb_wr) begin
			case (PADDR)
				OFS_CFG: cfg_en_r <= PWDATA[0];
				OFS_CTLBASE: base_r <= PWDATA[31:TBL_ALIGN];
				OFS_PRIOSET: prio_r <= prio_r | PWDATA;
				OFS_PRIOCLR: prio_r <= prio_r & ~PWDATA;
				OFS_MASKSET: mask_r <= mask_r | PWDATA;
				OFS_MASKCLR: mask_r <= mask_r & ~PWDATA;
				OFS_SECSET: sec_r <= sec_r | PWDATA;
				OFS_SECCLR: sec_r <= sec_r & ~PWDATA;
				default: cfg_en_r <= cfg_en_r;
			endcase
		end
	end

	// Channel enable: software set wins over a completion clear
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			en_r <= RST_WORD;
		end else begin
			en_r <= (en_r & ~hw_dis & ~((apb_wr && PADDR == OFS_ENACLR) ? PWDATA : '0)) |
				((apb_wr && PADDR == OFS_ENASET) ? PWDATA : '0);
		end
	end

	// Auto-run latch ends with the channel
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			auto_r <= RST_WORD;
		end else begin
			auto_r <= (auto_r | hw_auto) & ~hw_dis &
				~((apb_wr && PADDR == OFS_ENACLR) ? PWDATA : '0);
		end
	end

	// Software requests, consumed when the channel is granted
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			swreq_r <= RST_WORD;
		end else begin
			swreq_r <= (swreq_r & ~((st_r == ST_IDLE && |pend) ? (NCH'(1) << pick) : '0)) |
				((apb_wr && PADDR == OFS_SWREQ) ? PWDATA : '0);
		end
	end

	// Primary or alternate structure per channel
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			alt_r <= RST_WORD;
		end else begin
			alt_r <= (((alt_r ^ alt_tog) | alt_set1) & ~alt_clr1 &
				~((apb_wr && PADDR == OFS_ALTCLR) ? PWDATA : '0)) |
				((apb_wr && PADDR == OFS_ALTSET) ? PWDATA : '0);
		end
	end

	// Bus error flag, set wins over clear
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			err_r <= 1'b0;
		end else begin
			err_r <= bus_err | (err_r & ~(apb_wr && PADDR == OFS_ERRCLR && PWDATA[0]));
		end
	end

	// APB answer: one access cycle, unmapped reads zero with error
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= RST_WORD;
		end else begin
			pready_r <= PSEL & ~PENABLE;
			pslverr_r <= 1'b0;
			prdata_r <= RST_WORD;
			if (PSEL & ~PENABLE) begin
				case (PADDR)
					OFS_STATUS: prdata_r <= {11'h0, CH_MAX, 12'h0, st_r, cfg_en_r};
					OFS_CFG: prdata_r <= {31'h0, cfg_en_r};
					OFS_CTLBASE: prdata_r <= {base_r, 10'h0};
					OFS_ALTBASE: prdata_r <= {base_r, 1'b1, 9'h0};
					OFS_SWREQ: prdata_r <= swreq_r;
					OFS_ENASET, OFS_ENACLR: prdata_r <= en_r;
					OFS_MASKSET, OFS_MASKCLR: prdata_r <= mask_r;
					OFS_PRIOSET, OFS_PRIOCLR: prdata_r <= prio_r;
					OFS_ALTSET, OFS_ALTCLR: prdata_r <= alt_r;
					OFS_ERRCLR: prdata_r <= {31'h0, err_r};
					OFS_SECSET, OFS_SECCLR: prdata_r <= sec_r;
					default: pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	// Master request: start only while processor is off the bus
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			mreq_r <= 1'b0;
			mwr_r <= 1'b0;
			maddr_r <= RST_WORD;
			msize_r <= SZ_WORD;
			mwdata_r <= RST_WORD;
		end else if (bus_done) begin
			mreq_r <= 1'b0;
		end else if (!mreq_r && !CPU_BUSY) begin
			case (st_r)
				ST_FETCH: begin
					mreq_r <= 1'b1;
					mwr_r <= 1'b0;
					maddr_r <= struct_addr(base_r, sel_r, ch_r, wi_r);
					msize_r <= SZ_WORD;
				end
				ST_READ: begin
					mreq_r <= 1'b1;
					mwr_r <= 1'b0;
					maddr_r <= src_r;
					msize_r <= ctl_r[CTL_SIZE_LSB +: 2];
				end
				ST_WRITE: begin
					mreq_r <= 1'b1;
					mwr_r <= 1'b1;
					maddr_r <= dst_r;
					msize_r <= ctl_r[CTL_SIZE_LSB +: 2];
					mwdata_r <= lane_item(data_r, src_r[1:0], ctl_r[CTL_SIZE_LSB +: 2]);
				end
				ST_WBACK: begin
					mreq_r <= 1'b1;
					mwr_r <= 1'b1;
					maddr_r <= struct_addr(base_r, sel_r, ch_r, wi_r);
					msize_r <= SZ_WORD;
					mwdata_r <= (wi_r == W_SRC) ? src_r : (wi_r == W_DST) ? dst_r : ctl_r;
				end
				default: mreq_r <= 1'b0;
			endcase
		end
	end

	// Engine sequence: fetch, check, move one item, write back
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			st_r <= ST_IDLE;
			ch_r <= 5'h0;
			sel_r <= 1'b0;
			sw_hit_r <= 1'b0;
			last_r <= 1'b0;
			wi_r <= W_SRC;
			src_r <= RST_WORD;
			dst_r <= RST_WORD;
			ctl_r <= RST_WORD;
			data_r <= RST_WORD;
			mode_r <= MD_STOP;
		end else if (bus_err) begin
			st_r <= ST_IDLE;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (|pend) begin
						ch_r <= pick;
						sel_r <= alt_r[pick];
						sw_hit_r <= swreq_r[pick];
						wi_r <= W_SRC;
						st_r <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (bus_done) begin
						case (wi_r)
							W_SRC: src_r <= M_RDATA;
							W_DST: dst_r <= M_RDATA;
							default: ctl_r <= M_RDATA;
						endcase
						wi_r <= wi_r + 2'h1;
						st_r <= (wi_r == W_CTL) ? ST_CHECK : ST_FETCH;
					end
				end
				ST_CHECK: begin
					mode_r <= mode_cur;
					if (mode_cur == MD_STOP) begin
						st_r <= ST_IDLE;
					end else if (paced && !live_req[ch_r] && !sw_hit_r) begin
						st_r <= ST_IDLE; // pause without touching table
					end else begin
						st_r <= ST_READ;
					end
				end
				ST_READ: begin
					if (bus_done) begin
						data_r <= M_RDATA;
						st_r <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					if (bus_done) begin
						src_r <= src_r + step(ctl_r[CTL_SINC_LSB +: 2]);
						dst_r <= dst_r + step(ctl_r[CTL_DINC_LSB +: 2]);
						last_r <= (cnt_cur == '0);
						if (cnt_cur == '0) begin
							ctl_r[CTL_MODE_LSB +: 3] <= MD_STOP;
						end else begin
							ctl_r[CTL_CNT_LSB +: CTL_CNT_W] <= cnt_cur - 1'b1;
						end
						wi_r <= W_SRC;
						st_r <= ST_WBACK;
					end
				end
				ST_WBACK: begin
					if (bus_done) begin
						wi_r <= wi_r + 2'h1;
						st_r <= (wi_r == W_CTL) ? ST_IDLE : ST_WBACK;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Completion pulses: peripheral lines, software channel and errors on IRQ
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			done_r <= RST_WORD;
			irq_r <= 1'b0;
		end else begin
			done_r <= done_nxt & ~(NCH'(1) << SW_CH);
			irq_r <= done_nxt[SW_CH] | err_r;
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign PERIPH_DONE = done_r;
	assign IRQ = irq_r;
	assign M_REQ = mreq_r;
	assign M_WRITE = mwr_r;
	assign M_ADDR = maddr_r;
	assign M_SIZE = msize_r;
	assign M_WDATA = mwdata_r;
endmodule

// ==== test/mdma_ctrl_asserts.sv ====
// Port-level assertions of the micro DMA controller
module mdma_ctrl_asserts import mdma_pkg::*; #(
	parameter int SW_CH = 30
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [NCH-1:0] PERIPH_DONE,
	input wire logic IRQ,
	input wire logic CPU_BUSY,
	input wire logic M_REQ,
	input wire logic M_WRITE,
	input wire logic [31:0] M_ADDR,
	input wire logic [1:0] M_SIZE,
	input wire logic [31:0] M_WDATA,
	input wire logic M_ACK,
	input wire logic M_ERR
);
	logic [3:0] since_wack_r;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	// Cycles since the last acknowledged master write
	always_ff @(posedge CLK) begin
		if (!RESETN || (M_REQ && M_ACK && M_WRITE)) since_wack_r <= 4'h0;
		else if (since_wack_r != 4'hF) since_wack_r <= since_wack_r + 4'h1;
	end
	// Steps of a register access and of a master beat
	sequence s_setup; PSEL && !PENABLE; endsequence
	sequence s_answer; PREADY ##1 !PREADY; endsequence
	sequence s_beat; M_REQ && M_ACK; endsequence
	a_apb_answer: assert property (s_setup |=> s_answer)
		else $error("register access not answered after one cycle");
	a_err_resp: assert property (PSLVERR |-> PREADY)
		else $error("slave error outside an answer");
	a_cpu_yield: assert property ($rose(M_REQ) |-> !$past(CPU_BUSY))
		else $error("master request started while processor owned the bus");
	a_req_hold: assert property (M_REQ && !M_ACK |=> M_REQ && $stable(M_ADDR)
		&& $stable(M_WRITE) && $stable(M_SIZE) && $stable(M_WDATA))
		else $error("master request changed before acknowledge");
	a_req_release: assert property (s_beat |=> !M_REQ)
		else $error("master request not released after acknowledge");
	a_done_pulse: assert property (|PERIPH_DONE |=> (PERIPH_DONE & $past(PERIPH_DONE)) == '0)
		else $error("completion pulse longer than one cycle");
	a_done_cause: assert property (|PERIPH_DONE |-> since_wack_r <= 4'h2)
		else $error("completion pulse without a final writeback");
	a_sw_route: assert property (!PERIPH_DONE[SW_CH])
		else $error("software channel completion on a peripheral line");
	a_size_legal: assert property (M_REQ |-> M_SIZE != 2'h3)
		else $error("illegal item size on master bus");
	a_addr_align: assert property (M_REQ |-> !(M_SIZE == SZ_WORD && M_ADDR[1:0] != 2'h0)
		&& !(M_SIZE == SZ_HALF && M_ADDR[0]))
		else $error("misaligned master address");
	a_err_irq: assert property (s_beat ##0 M_ERR |-> ##[1:3] IRQ)
		else $error("bus error did not raise the interrupt");
endmodule

// ==== test/mdma_bus_model.sv ====
// System memory behind the controller's bus master, with wait states and error
module mdma_bus_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic [31:0] err_addr,
	input wire logic m_req,
	input wire logic m_write,
	input wire logic [31:0] m_addr,
	input wire logic [1:0] m_size,
	input wire logic [31:0] m_wdata,
	output logic m_ack,
	output logic m_err,
	output logic [31:0] m_rdata
);
	logic [31:0] mem [0:1023];
	logic [31:0] junk_r;
	logic [1:0] wait_r;
	logic [3:0] be;
	// Byte lanes touched by the access
	always_comb begin
		case (m_size)
			2'h0: be = 4'h1 << m_addr[1:0];
			2'h1: be = m_addr[1] ? 4'hC : 4'h3;
			default: be = 4'hF;
		endcase
	end
	// Answer after optional wait states; read data is junk outside an answer
	// Plain always: the bench preloads the same memory between accesses
	always @(posedge clk) begin
		m_ack <= 1'b0;
		m_err <= 1'b0;
		m_rdata <= junk_r;
		junk_r <= ~junk_r + 32'h1;
		if (!resetn) begin
			wait_r <= 2'h0;
			junk_r <= 32'hA5A5A5A5;
		end else if (m_req && !m_ack) begin
			if (slow && wait_r != 2'h3) wait_r <= wait_r + 2'h1;
			else begin
				wait_r <= 2'h0;
				m_ack <= 1'b1;
				m_err <= m_addr == err_addr;
				m_rdata <= mem[m_addr[11:2]];
				for (int b = 0; b < 4; b++)
					if (m_write && be[b]) mem[m_addr[11:2]][8*b+:8] <= m_wdata[8*b+:8];
			end
		end
	end
endmodule

// ==== test/mdma_ctrl_tb.sv ====
// Bench of the micro DMA controller against its memory partner
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module mdma_ctrl_tb import mdma_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} mdma_row_t;
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, irq, m_req, m_write, m_ack, m_err, re;
	logic cpu_busy = 1'b0, slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, m_addr, m_wdata, m_rdata, rq, c;
	logic [31:0] err_addr = 32'hFFFFFFFC, first_w = 32'h0;
	logic [NCH-1:0] preq = '0, preq_sec = '0, pdone, seen = '0;
	logic [1:0] m_size;
	int n_fail = 0, cmp_count = 0, irq_n = 0, pp_n = 0;
	mdma_row_t rows [12] = '{'{OFS_STATUS, 32'h001F0000, 1'b0}, '{OFS_CFG, 32'h0, 1'b0},
		'{OFS_CTLBASE, 32'h0, 1'b0}, '{OFS_ALTBASE, 32'h200, 1'b0},
		'{OFS_ENASET, 32'h0, 1'b0}, '{OFS_MASKSET, 32'h0, 1'b0},
		'{OFS_PRIOSET, 32'h0, 1'b0}, '{OFS_ALTSET, 32'h0, 1'b0},
		'{OFS_ERRCLR, 32'h0, 1'b0}, '{OFS_SECSET, 32'h0, 1'b0},
		'{12'h040, 32'h0, 1'b1}, '{12'hFFC, 32'h0, 1'b1}};
	mdma_ctrl #(.SW_CH(30)) dut_u (.CLK(clk), .RESETN(resetn), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PERIPH_REQ(preq), .PERIPH_REQ_SEC(preq_sec),
		.PERIPH_DONE(pdone), .IRQ(irq), .CPU_BUSY(cpu_busy), .M_REQ(m_req), .M_WRITE(m_write),
		.M_ADDR(m_addr), .M_SIZE(m_size), .M_WDATA(m_wdata), .M_ACK(m_ack), .M_ERR(m_err),
		.M_RDATA(m_rdata));
	mdma_bus_model bm_u (.clk, .resetn, .slow, .err_addr, .m_req, .m_write, .m_addr,
		.m_size, .m_wdata, .m_ack, .m_err, .m_rdata);
	// Clock, 25 ns period
	always #12.5 clk = ~clk;
	// Completion and interrupt tallies, first data write seen
	always @(posedge clk) begin
		if (resetn) begin
			seen <= seen | pdone;
			pp_n <= pp_n + int'(pdone[5] === 1'b1);
			irq_n <= irq_n + int'(irq === 1'b1);
			if (m_req && m_ack && m_write && m_addr[11:8] == 4'h9 && first_w == 32'h0)
				first_w <= m_addr;
		end
	end
	// Report counts and verdict
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic tmo();
		n_fail++;
		tally_and_finish();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer, held until the answer, then one idle edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) tmo();
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rq);
	endtask
	task automatic mchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
		`CHK(nm, ex, bm_u.mem[a[11:2]]);
	endtask
	// Control word: mode, item count, size, source and destination steps
	function automatic logic [31:0] cw(input logic [2:0] md, input logic [9:0] n,
		input logic [1:0] sz, input logic [1:0] si, input logic [1:0] di);
		logic [9:0] m;
		m = n - 10'h1;
		return {di, 2'h0, si, sz, 10'h000, m, 1'b0, md};
	endfunction
	// Source, destination and control of one structure in the table at 0x400
	task automatic setch(input int ch, input int alt, input logic [31:0] s,
		input logic [31:0] d, input logic [31:0] w);
		int i;
		i = 256 + alt * 128 + ch * 4;
		bm_u.mem[i] = s;
		bm_u.mem[i+1] = d;
		bm_u.mem[i+2] = w;
	endtask
	task automatic wait_off(input int ch);
		int k;
		k = 0;
		do begin
			apb(1'b0, OFS_ENASET, 32'h0);
			k++;
		end while (rq[ch] !== 1'b0 && k < 100);
		if (k >= 100) tmo();
	endtask
	// Main sequence
	initial begin
		for (int i = 576; i < 640; i++) bm_u.mem[i] = 32'h0;
		idle(4);
		resetn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			rd("register reset", rows[i].a, rows[i].d);
			`CHK("slave error", rows[i].e, re);
		end
		wr(OFS_CTLBASE, 32'h00000400);
		rd("alternate base", OFS_ALTBASE, 32'h00000600);
		// Software channel auto run, held off by global enable and processor
		for (int i = 0; i < 3; i++) bm_u.mem[512 + i] = 32'hA0B0C000 + i;
		c = cw(MD_AUTO, 10'h3, SZ_WORD, SZ_WORD, SZ_WORD);
		setch(30, 0, 32'h800, 32'h900, c);
		wr(OFS_ENASET, 32'h40000000);
		wr(OFS_SWREQ, 32'h40000000);
		idle(30);
		mchk("disabled controller", 32'h900, 32'h0);
		cpu_busy <= 1'b1;
		wr(OFS_CFG, 32'h1);
		wr(OFS_SWREQ, 32'h40000000);
		idle(20);
		mchk("processor owns bus", 32'h900, 32'h0);
		cpu_busy <= 1'b0;
		wait_off(30);
		for (int i = 0; i < 3; i++) mchk("auto data", 32'h900 + 4 * i, 32'hA0B0C000 + i);
		mchk("source advanced", 32'h5E0, 32'h0000080C);
		mchk("stopped control", 32'h5E8, c & 32'hFFFFC000);
		`CHK("software irq cycles", 1, irq_n);
		`CHK("no peripheral done", 1'b0, seen[30]);
		// Basic byte channel: no request, then masked, then released
		slow <= 1'b1;
		bm_u.mem[528] = 32'h44332211;
		c = cw(MD_BASIC, 10'h4, SZ_BYTE, SZ_BYTE, INC_NONE);
		setch(3, 0, 32'h840, 32'h980, c);
		wr(OFS_ENASET, 32'h8);
		idle(40);
		mchk("no request", 32'h980, 32'h0);
		wr(OFS_MASKSET, 32'h8);
		preq[3] <= 1'b1;
		idle(40);
		mchk("masked request", 32'h980, 32'h0);
		wr(OFS_MASKCLR, 32'h8);
		wait_off(3);
		mchk("byte data", 32'h980, 32'h00000044);
		mchk("byte source", 32'h430, 32'h00000844);
		mchk("fixed destination", 32'h434, 32'h00000980);
		`CHK("peripheral done", 1'b1, seen[3]);
		`CHK("irq untouched", 1, irq_n);
		preq[3] <= 1'b0;
		// Ping-pong half-words paced by the secondary request source
		bm_u.mem[536] = 32'hBEEF1234;
		bm_u.mem[540] = 32'hCAFE5678;
		c = cw(MD_PINGPONG, 10'h2, SZ_HALF, SZ_HALF, SZ_HALF);
		setch(5, 0, 32'h860, 32'h9A0, c);
		setch(5, 1, 32'h870, 32'h9B0, c);
		wr(OFS_SECSET, 32'h20);
		wr(OFS_ENASET, 32'h20);
		preq_sec[5] <= 1'b1;
		wait_off(5);
		mchk("primary buffer", 32'h9A0, 32'hBEEF1234);
		mchk("alternate buffer", 32'h9B0, 32'hCAFE5678);
		mchk("alternate stopped", 32'h658, c & 32'hFFFFC000);
		`CHK("ping-pong dones", 2, pp_n);
		preq_sec[5] <= 1'b0;
		// Channels 0 and 31 requested together, first with priority, then without
		slow <= 1'b0;
		bm_u.mem[544] = 32'h11111111;
		c = cw(MD_AUTO, 10'h1, SZ_WORD, SZ_WORD, SZ_WORD);
		for (int r = 0; r < 2; r++) begin
			first_w <= 32'h0;
			setch(0, 0, 32'h880, 32'h9C0, c);
			setch(31, 0, 32'h880, 32'h9C4, c);
			wr(r ? OFS_PRIOCLR : OFS_PRIOSET, 32'h80000000);
			wr(OFS_ENASET, 32'h80000001);
			wr(OFS_SWREQ, 32'h80000001);
			wait_off(0);
			wait_off(31);
			`CHK("first winner", r ? 32'h000009C0 : 32'h000009C4, first_w);
		end
		// Bus error on a source read: flag holds until cleared
		err_addr <= 32'h000008F0;
		setch(30, 0, 32'h8F0, 32'h9D0, c);
		wr(OFS_ENASET, 32'h40000000);
		wr(OFS_SWREQ, 32'h40000000);
		wait_off(30);
		idle(10);
		`CHK("error irq held", 1'b1, irq);
		rd("error flag", OFS_ERRCLR, 32'h1);
		wr(OFS_ERRCLR, 32'h1);
		idle(2);
		`CHK("error irq cleared", 1'b0, irq);
		// Scatter-gather: one task copied into the alternate structure, then run
		for (int r = 0; r < 2; r++) begin
			bm_u.mem[552] = 32'h000008B0;
			bm_u.mem[553] = 32'h000009E0 + 4 * r;
			bm_u.mem[554] = c;
			bm_u.mem[555] = 32'h0;
			bm_u.mem[556] = 32'h5A5A0000 + r;
			setch(r ? 3 : 30, 0, 32'h8A0, r ? 32'h630 : 32'h7E0,
				cw(r ? MD_PSG : MD_MSG, 10'h4, SZ_WORD, SZ_WORD, SZ_WORD));
			wr(OFS_ENASET, r ? 32'h8 : 32'h40000000);
			wr(OFS_SWREQ, r ? 32'h0 : 32'h40000000);
			idle(40);
			mchk("paced task list", 32'h9E4, 32'h0);
			preq[3] <= 1'b1;
			wait_off(r ? 3 : 30);
			mchk("task data", 32'h9E0 + 4 * r, 32'h5A5A0000 + r);
			mchk("task stopped", r ? 32'h638 : 32'h7E8, c & 32'hFFFFC000);
			preq[3] <= 1'b0;
		end
		rd("status idle", OFS_STATUS, 32'h001F0001);
		tally_and_finish();
	end
endmodule
bind mdma_ctrl mdma_ctrl_asserts #(.SW_CH(SW_CH)) chk_u (.CLK, .RESETN, .PSEL, .PENABLE,
	.PREADY, .PSLVERR, .PERIPH_DONE, .IRQ, .CPU_BUSY, .M_REQ, .M_WRITE, .M_ADDR, .M_SIZE,
	.M_WDATA, .M_ACK, .M_ERR);
